/* include/psc_consts.vh */
// constants for the port statistics counter block
`ifndef PSC_CONSTS_VH
`define PSC_CONSTS_VH

// ***************************************************
// counter widths
// ***************************************************
`define PSC_CNT_W        32
`define PSC_LEN_W        14
`define PSC_COLL_W       5
`define PSC_CNT_ZERO     32'h00000000
`define PSC_CNT_ONE      32'h00000001

// ***************************************************
// frame and collision limits
// ***************************************************
`define PSC_MIN_FRAME    14'h0040
`define PSC_MAX_FRAME    14'h05EE
`define PSC_LATE_BITS    16'h0200
`define PSC_BITS_PER_B   16'h0008
`define PSC_MAX_RETRY    5'h10

// ***************************************************
// timing: 100 MHz clock, one second window
// ***************************************************
`define PSC_CLK_HZ       100000000
`define PSC_SEC_CYCLES   27'h5F5E0FF
`define PSC_KB_SHIFT     10
`define PSC_CYC_ZERO     27'h0000000

`endif

/* src/psc_wrap_cnt.v */
// wrapping event counter with synchronous clear
`timescale 1ns/100ps
`include "psc_consts.vh"
module psc_wrap_cnt (
  input  wire                  clk,
  input  wire                  rst,
  input  wire                  clr,
  input  wire                  inc,
  output reg  [`PSC_CNT_W-1:0] cnt_r
);

  // clear beats increment; wraps past all ones
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= `PSC_CNT_ZERO;
    end else if (clr) begin
      cnt_r <= `PSC_CNT_ZERO;
    end else if (inc) begin
      cnt_r <= cnt_r + `PSC_CNT_ONE;
    end
  end
endmodule

/* src/psc_rate_meter.v */
// bytes per second meter, result in kilobytes per second
`timescale 1ns/100ps
`include "psc_consts.vh"
module psc_rate_meter (
  input  wire                  clk,
  input  wire                  rst,
  input  wire                  clr,
  input  wire                  sec_tick,
  input  wire                  byte_vld,
  input  wire [`PSC_LEN_W-1:0] byte_cnt,
  output reg  [`PSC_CNT_W-1:0] rate_r
);

  reg [`PSC_CNT_W-1:0] acc_r;
  wire [`PSC_CNT_W-1:0] add_w = {{(`PSC_CNT_W-`PSC_LEN_W){1'b0}}, byte_cnt};

  // accumulate bytes, latch once a second
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_r  <= `PSC_CNT_ZERO;
      rate_r <= `PSC_CNT_ZERO;
    end else if (clr) begin
      acc_r  <= `PSC_CNT_ZERO;
      rate_r <= `PSC_CNT_ZERO;
    end else if (sec_tick) begin
      // frame ending on the tick goes into the next window
      acc_r  <= byte_vld ? add_w : `PSC_CNT_ZERO;
      rate_r <= acc_r >> `PSC_KB_SHIFT;
    end else if (byte_vld) begin
      acc_r  <= acc_r + add_w;
    end
  end
endmodule

/* src/psc_port_stats.v */
// per-port ethernet statistics counters
//
// Functional notes
// RULE_01: count good transmitted unicast frames
// RULE_02: count good transmitted multicast frames
// RULE_03: count good transmitted broadcast frames
// RULE_04: count every transmitted pause frame
// RULE_05: count good received unicast frames
// RULE_06: count good received multicast frames
// RULE_07: count good received broadcast frames
// RULE_08: count every received pause frame
// RULE_09: sent after exactly one collision
// RULE_10: sent after two or more collisions
// RULE_11: abandoned at retry limit collisions
// RULE_12: collision after 512 bit times is late
// RULE_13: count received frames with bad CRC
// RULE_14: count received frames length out of range
// RULE_15: count frames under 64 octets, CRC included
// RULE_16: count received frames exactly 64 octets
// RULE_17: transmit rate in kilobytes per second
// RULE_18: receive rate in kilobytes per second
// RULE_19: accumulate continuous link up time
// RULE_20: clear this port or all ports
// RULE_21: total count of errored received frames
// RULE_22: counters wrap, update once per frame
`timescale 1ns/100ps
`include "psc_consts.vh"
module psc_port_stats (
  // clock, reset, clear requests and link status
  input  wire                  clk,
  input  wire                  rst,
  input  wire                  clr_port,
  input  wire                  clr_all,
  input  wire                  link_up,
  // transmit side events, qualifiers valid with tx_done
  input  wire                  tx_done,
  input  wire                  tx_ok,
  input  wire                  tx_ucast,
  input  wire                  tx_mcast,
  input  wire                  tx_bcast,
  input  wire                  tx_pause,
  input  wire [`PSC_LEN_W-1:0] tx_len,
  input  wire                  tx_coll,
  input  wire [15:0]           tx_bit_pos,
  // receive side events, qualifiers valid with rx_done
  input  wire                  rx_done,
  input  wire                  rx_ucast,
  input  wire                  rx_mcast,
  input  wire                  rx_bcast,
  input  wire                  rx_pause,
  input  wire [`PSC_LEN_W-1:0] rx_len,
  input  wire                  rx_crc_err,
  // counters, all straight from flip-flops
  output wire [`PSC_CNT_W-1:0] tx_ucast_cnt,
  output wire [`PSC_CNT_W-1:0] tx_mcast_cnt,
  output wire [`PSC_CNT_W-1:0] tx_bcast_cnt,
  output wire [`PSC_CNT_W-1:0] tx_pause_cnt,
  output wire [`PSC_CNT_W-1:0] rx_ucast_cnt,
  output wire [`PSC_CNT_W-1:0] rx_mcast_cnt,
  output wire [`PSC_CNT_W-1:0] rx_bcast_cnt,
  output wire [`PSC_CNT_W-1:0] rx_pause_cnt,
  output wire [`PSC_CNT_W-1:0] coll_single_cnt,
  output wire [`PSC_CNT_W-1:0] coll_multi_cnt,
  output wire [`PSC_CNT_W-1:0] coll_excess_cnt,
  output wire [`PSC_CNT_W-1:0] coll_late_cnt,
  output wire [`PSC_CNT_W-1:0] rx_crc_cnt,
  output wire [`PSC_CNT_W-1:0] rx_len_err_cnt,
  output wire [`PSC_CNT_W-1:0] rx_runt_cnt,
  output wire [`PSC_CNT_W-1:0] rx_hist64_cnt,
  output wire [`PSC_CNT_W-1:0] rx_err_cnt,
  output wire [`PSC_CNT_W-1:0] transmit_rate,
  output wire [`PSC_CNT_W-1:0] receive_rate,
  output reg  [`PSC_CNT_W-1:0] up_time_r
);

  // number of plain event counters in the vector
  localparam NCNT = 17;

  // ***************************************************
  // clear and one second tick
  // ***************************************************

  // clear outranks every increment; an event in the clear cycle is lost, for late and excessive collisions the one a cycle earlier
  // clearing this port or all ports has the same local effect
  // RULE_20: either clear request
  wire clr_w = clr_port | clr_all;

  // one second divider, a full second needs 27 bits
  reg [26:0] sec_div_r;
  reg        sec_tick_r;

  // tick is registered, so it lands one cycle after the terminal count
  // divider gives one-cycle enable every second
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sec_div_r  <= `PSC_CYC_ZERO;
      sec_tick_r <= 1'b0;
    end else if (sec_div_r == `PSC_SEC_CYCLES) begin
      sec_div_r  <= `PSC_CYC_ZERO;
      sec_tick_r <= 1'b1;
    end else begin
      sec_div_r  <= sec_div_r + 27'h0000001;
      sec_tick_r <= 1'b0;
    end
  end

  // ***************************************************
  // collision tracking per frame
  // ***************************************************
  // retry count of the frame in flight
  reg [`PSC_COLL_W-1:0] coll_cnt_r;
  reg [`PSC_COLL_W-1:0] coll_cnt_nxt;
  reg                   excess_r;
  reg                   late_r;
  reg                   excess_nxt;
  reg                   late_nxt;

  // tx_coll is tested first, so it wins over tx_done if both share a cycle
  // attempts of one frame accumulate until tx_done
  always @* begin
    coll_cnt_nxt = coll_cnt_r;
    excess_nxt   = 1'b0;
    late_nxt     = 1'b0;
    if (tx_coll) begin
      // RULE_12: late past 512 bits
      // exactly 512 bits sent is still inside the slot time
      late_nxt = (tx_bit_pos > `PSC_LATE_BITS);
      // the limit collision ends the frame; the count restarts
      // RULE_11: retry limit reached
      if (coll_cnt_r + 5'h01 >= `PSC_MAX_RETRY) begin
        excess_nxt   = 1'b1;
        coll_cnt_nxt = 5'h00;
      end else begin
        coll_cnt_nxt = coll_cnt_r + 5'h01;
      end
    end else if (tx_done) begin
      // sent or abandoned, the next frame starts from zero
      coll_cnt_nxt = 5'h00;
    end
  end

  // excess and late are registered for a clean one-cycle strobe; costs a cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      coll_cnt_r <= 5'h00;
      excess_r   <= 1'b0;
      late_r     <= 1'b0;
    end else begin
      coll_cnt_r <= coll_cnt_nxt;
      excess_r   <= excess_nxt;
      late_r     <= late_nxt;
    end
  end

  // ***************************************************
  // increment strobes, one per counter
  // ***************************************************

  // slot map of the counter vector, low to high:
  //   0..3   tx unicast, multicast, broadcast, pause
  //   4..7   rx unicast, multicast, broadcast, pause
  //   8..11  single, multiple, excessive and late collisions
  //   12..15 crc, length, runt, smallest size bin
  //   16     any receive error
  // a runt is also a length error, so it lands in both counts

  // a frame is good only at its own done strobe
  wire tx_good = tx_done & tx_ok;
  // length classes of the received frame
  wire rx_runt = rx_len < `PSC_MIN_FRAME;
  wire rx_lerr = rx_runt | (rx_len > `PSC_MAX_FRAME);
  wire rx_good = rx_done & ~rx_crc_err & ~rx_lerr;
  // strobes and the packed counter vector
  wire [NCNT-1:0] inc_w;
  wire [`PSC_CNT_W*NCNT-1:0] cnt_w;

  // RULE_01: good tx unicast
  assign inc_w[0]  = tx_good & tx_ucast;
  // RULE_02: good tx multicast
  assign inc_w[1]  = tx_good & tx_mcast;
  // RULE_03: good tx broadcast
  assign inc_w[2]  = tx_good & tx_bcast;
  // pause frames count whether or not the send succeeded
  // RULE_04: all tx pause
  assign inc_w[3]  = tx_done & tx_pause;

  // receive unicast, multicast and broadcast need crc and length both clean; pause counts at any frame end
  // RULE_05: good rx unicast
  assign inc_w[4]  = rx_good & rx_ucast;
  // RULE_06: good rx multicast
  assign inc_w[5]  = rx_good & rx_mcast;
  // RULE_07: good rx broadcast
  assign inc_w[6]  = rx_good & rx_bcast;
  // RULE_08: all rx pause
  assign inc_w[7]  = rx_done & rx_pause;

  // collision classes: single and multiple read at the done of a sent frame, excessive and late from their registered strobes
  // RULE_09: one collision then sent
  assign inc_w[8]  = tx_good & (coll_cnt_r == 5'h01);
  // RULE_10: several collisions then sent
  assign inc_w[9]  = tx_good & (coll_cnt_r > 5'h01);
  // RULE_11: excessive abandon
  assign inc_w[10] = excess_r;
  // RULE_12: late collision seen
  assign inc_w[11] = late_r;

  // receive error classes and the smallest size bin, at any frame end
  // RULE_13: rx crc mismatch
  assign inc_w[12] = rx_done & rx_crc_err;
  // RULE_14: rx length range
  assign inc_w[13] = rx_done & rx_lerr;
  // RULE_15: short frames incl crc
  assign inc_w[14] = rx_done & rx_runt;
  // RULE_16: exactly 64 octets
  assign inc_w[15] = rx_done & (rx_len == `PSC_MIN_FRAME);
  // RULE_21: any rx error
  assign inc_w[16] = rx_done & (rx_crc_err | rx_lerr);

  // one counter per slot; a read never stalls a count
  // RULE_22: wrapping, one step per frame
  genvar gi;
  generate
    for (gi = 0; gi < NCNT; gi = gi + 1) begin : g_cnt
      psc_wrap_cnt u_cnt (
        .clk   (clk),
        .rst   (rst),
        .clr   (clr_w),
        .inc   (inc_w[gi]),
        .cnt_r (cnt_w[gi*`PSC_CNT_W +: `PSC_CNT_W])
      );
    end
  endgenerate

  // transmit classes
  assign tx_ucast_cnt    = cnt_w[0*`PSC_CNT_W +: `PSC_CNT_W];
  assign tx_mcast_cnt    = cnt_w[1*`PSC_CNT_W +: `PSC_CNT_W];
  assign tx_bcast_cnt    = cnt_w[2*`PSC_CNT_W +: `PSC_CNT_W];
  assign tx_pause_cnt    = cnt_w[3*`PSC_CNT_W +: `PSC_CNT_W];

  // receive classes
  assign rx_ucast_cnt    = cnt_w[4*`PSC_CNT_W +: `PSC_CNT_W];
  assign rx_mcast_cnt    = cnt_w[5*`PSC_CNT_W +: `PSC_CNT_W];
  assign rx_bcast_cnt    = cnt_w[6*`PSC_CNT_W +: `PSC_CNT_W];
  assign rx_pause_cnt    = cnt_w[7*`PSC_CNT_W +: `PSC_CNT_W];

  // collision classes
  assign coll_single_cnt = cnt_w[8*`PSC_CNT_W +: `PSC_CNT_W];
  assign coll_multi_cnt  = cnt_w[9*`PSC_CNT_W +: `PSC_CNT_W];
  assign coll_excess_cnt = cnt_w[10*`PSC_CNT_W +: `PSC_CNT_W];
  assign coll_late_cnt   = cnt_w[11*`PSC_CNT_W +: `PSC_CNT_W];

  // receive errors and smallest size bin
  assign rx_crc_cnt      = cnt_w[12*`PSC_CNT_W +: `PSC_CNT_W];
  assign rx_len_err_cnt  = cnt_w[13*`PSC_CNT_W +: `PSC_CNT_W];
  assign rx_runt_cnt     = cnt_w[14*`PSC_CNT_W +: `PSC_CNT_W];
  assign rx_hist64_cnt   = cnt_w[15*`PSC_CNT_W +: `PSC_CNT_W];
  assign rx_err_cnt      = cnt_w[16*`PSC_CNT_W +: `PSC_CNT_W];

  // ***************************************************
  // throughput meters
  // ***************************************************

  // both meters share the tick, so their windows line up
  // RULE_17: tx bytes per second
  psc_rate_meter u_tx_rate (
    .clk      (clk),
    .rst      (rst),
    .clr      (clr_w),
    .sec_tick (sec_tick_r),
    .byte_vld (tx_good),
    .byte_cnt (tx_len),
    .rate_r   (transmit_rate)
  );

  // errored frames count too: they used the line
  // RULE_18: rx bytes per second
  psc_rate_meter u_rx_rate (
    .clk      (clk),
    .rst      (rst),
    .clr      (clr_w),
    .sec_tick (sec_tick_r),
    .byte_vld (rx_done),
    .byte_cnt (rx_len),
    .rate_r   (receive_rate)
  );

  // ***************************************************
  // link up time in seconds
  // ***************************************************

  // whole seconds only; a drop mid second loses the fraction
  // restarts from zero whenever the link drops
  // RULE_19: seconds of continuous link
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      up_time_r <= `PSC_CNT_ZERO;
    end else if (clr_w | ~link_up) begin
      up_time_r <= `PSC_CNT_ZERO;
    end else if (sec_tick_r) begin
      up_time_r <= up_time_r + `PSC_CNT_ONE;
    end
  end
endmodule

/* tb/psc_link_partner.sv */
// link partner model that delivers received frame ends to the stats block
`timescale 1ns/100ps
`include "psc_consts.vh"
module psc_link_partner (
  input  wire                  clk,
  input  wire                  rst,
  input  wire                  go,
  input  wire [3:0]            kind,
  input  wire [`PSC_LEN_W-1:0] len,
  input  wire                  bad,
  output reg                   rx_done,
  output reg                   rx_ucast,
  output reg                   rx_mcast,
  output reg                   rx_bcast,
  output reg                   rx_pause,
  output reg  [`PSC_LEN_W-1:0] rx_len,
  output reg                   rx_crc_err
);
  // one frame end per go; qualifiers churn between frames so stale values never count
  // quiet during reset, single driver per output
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_done    <= 1'b0;
      {rx_pause, rx_bcast, rx_mcast, rx_ucast} <= 4'h0;
      rx_len     <= 14'h0000;
      rx_crc_err <= 1'b0;
    end else begin
      rx_done    <= go;
      {rx_pause, rx_bcast, rx_mcast, rx_ucast} <= go ? kind :
        ~{rx_pause, rx_bcast, rx_mcast, rx_ucast};
      rx_len     <= go ? len : ~rx_len;
      rx_crc_err <= go ? bad : ~rx_crc_err;
    end
  end
endmodule

/* tb/psc_chk.sv */
// concurrent checks on the port statistics counter ports
`timescale 1ns/100ps
`include "psc_consts.vh"
module psc_chk (
  input wire        clk,
  input wire        rst,
  input wire        clr_port,
  input wire        clr_all,
  input wire        tx_done,
  input wire        tx_ok,
  input wire        tx_ucast,
  input wire        tx_coll,
  input wire [15:0] tx_bit_pos,
  input wire        rx_done,
  input wire        rx_ucast,
  input wire [13:0] rx_len,
  input wire        rx_crc_err,
  input wire [31:0] tx_ucast_cnt,
  input wire [31:0] rx_ucast_cnt,
  input wire [31:0] coll_late_cnt,
  input wire [31:0] rx_crc_cnt,
  input wire [31:0] rx_err_cnt,
  input wire [31:0] rx_runt_cnt,
  input wire [31:0] rx_hist64_cnt
);
  // clear from either request; good frame needs crc and legal length
  wire clr   = clr_port | clr_all;
  wire rx_ok = !rx_crc_err && rx_len >= `PSC_MIN_FRAME && rx_len <= `PSC_MAX_FRAME;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // late collision, no clear while its count is in flight
  sequence late_s;
    tx_coll && tx_bit_pos > `PSC_LATE_BITS && !clr ##1 !clr;
  endsequence
  rx_ucast_a:
    assert property (rx_done && rx_ucast && rx_ok && !clr |=> rx_ucast_cnt == $past(rx_ucast_cnt) + 1)
      else $error("rx unicast not counted");
  tx_ucast_a:
    assert property (tx_done && tx_ok && tx_ucast && !clr |=> tx_ucast_cnt == $past(tx_ucast_cnt) + 1)
      else $error("tx unicast not counted");
  rx_crc_a:
    assert property (rx_done && rx_crc_err && !clr |=> rx_crc_cnt == $past(rx_crc_cnt) + 1)
      else $error("crc error not counted");
  rx_err_a:
    assert property (rx_done && !rx_ok && !clr |=> rx_err_cnt == $past(rx_err_cnt) + 1)
      else $error("errored frame not counted");
  runt_cnt_a:
    assert property (rx_done && rx_len < `PSC_MIN_FRAME && !clr |=> rx_runt_cnt == $past(rx_runt_cnt) + 1)
      else $error("runt not counted");
  hist_bin_a:
    assert property (rx_done && rx_len == `PSC_MIN_FRAME && !clr |=> rx_hist64_cnt == $past(rx_hist64_cnt) + 1)
      else $error("smallest bin not counted");
  late_coll_a:
    assert property (late_s |=> coll_late_cnt == $past(coll_late_cnt) + 1)
      else $error("late collision not counted");
  clear_all_a:
    assert property (clr |=> rx_ucast_cnt == 0 && tx_ucast_cnt == 0 && rx_err_cnt == 0)
      else $error("clear left counts");
endmodule
bind psc_port_stats psc_chk u_psc_chk (
  .clk           (clk),
  .rst           (rst),
  .clr_port      (clr_port),
  .clr_all       (clr_all),
  .tx_done       (tx_done),
  .tx_ok         (tx_ok),
  .tx_ucast      (tx_ucast),
  .tx_coll       (tx_coll),
  .tx_bit_pos    (tx_bit_pos),
  .rx_done       (rx_done),
  .rx_ucast      (rx_ucast),
  .rx_len        (rx_len),
  .rx_crc_err    (rx_crc_err),
  .tx_ucast_cnt  (tx_ucast_cnt),
  .rx_ucast_cnt  (rx_ucast_cnt),
  .coll_late_cnt (coll_late_cnt),
  .rx_crc_cnt    (rx_crc_cnt),
  .rx_err_cnt    (rx_err_cnt),
  .rx_runt_cnt   (rx_runt_cnt),
  .rx_hist64_cnt (rx_hist64_cnt)
);

/* tb/psc_port_stats_tb.sv */
// self-checking bench for the port statistics counters
`timescale 1ns/100ps
`include "psc_consts.vh"
module psc_port_stats_tb;
  reg clk = 1'b0;
  reg rst, clr_port, clr_all, link_up, tx_done, tx_ok, tx_ucast, tx_mcast, tx_bcast;
  reg tx_pause, tx_coll, go, bad;
  reg [3:0] kind;
  reg [13:0] tx_len, len;
  reg [15:0] tx_bit_pos;
  wire rx_done, rx_ucast, rx_mcast, rx_bcast, rx_pause, rx_crc_err;
  wire [13:0] rx_len;
  wire [31:0] tx_ucast_cnt, tx_mcast_cnt, tx_bcast_cnt, tx_pause_cnt, rx_ucast_cnt, rx_mcast_cnt;
  wire [31:0] rx_bcast_cnt, rx_pause_cnt, coll_single_cnt, coll_multi_cnt, coll_excess_cnt;
  wire [31:0] coll_late_cnt, rx_crc_cnt, rx_len_err_cnt, rx_runt_cnt, rx_hist64_cnt, rx_err_cnt;
  wire [31:0] transmit_rate, receive_rate, up_time_r;
  integer err_total, checks_done, i;
  psc_port_stats u_psc_port_stats (
    .clk             (clk),
    .rst             (rst),
    .clr_port        (clr_port),
    .clr_all         (clr_all),
    .link_up         (link_up),
    .tx_done         (tx_done),
    .tx_ok           (tx_ok),
    .tx_ucast        (tx_ucast),
    .tx_mcast        (tx_mcast),
    .tx_bcast        (tx_bcast),
    .tx_pause        (tx_pause),
    .tx_len          (tx_len),
    .tx_coll         (tx_coll),
    .tx_bit_pos      (tx_bit_pos),
    .rx_done         (rx_done),
    .rx_ucast        (rx_ucast),
    .rx_mcast        (rx_mcast),
    .rx_bcast        (rx_bcast),
    .rx_pause        (rx_pause),
    .rx_len          (rx_len),
    .rx_crc_err      (rx_crc_err),
    .tx_ucast_cnt    (tx_ucast_cnt),
    .tx_mcast_cnt    (tx_mcast_cnt),
    .tx_bcast_cnt    (tx_bcast_cnt),
    .tx_pause_cnt    (tx_pause_cnt),
    .rx_ucast_cnt    (rx_ucast_cnt),
    .rx_mcast_cnt    (rx_mcast_cnt),
    .rx_bcast_cnt    (rx_bcast_cnt),
    .rx_pause_cnt    (rx_pause_cnt),
    .coll_single_cnt (coll_single_cnt),
    .coll_multi_cnt  (coll_multi_cnt),
    .coll_excess_cnt (coll_excess_cnt),
    .coll_late_cnt   (coll_late_cnt),
    .rx_crc_cnt      (rx_crc_cnt),
    .rx_len_err_cnt  (rx_len_err_cnt),
    .rx_runt_cnt     (rx_runt_cnt),
    .rx_hist64_cnt   (rx_hist64_cnt),
    .rx_err_cnt      (rx_err_cnt),
    .transmit_rate   (transmit_rate),
    .receive_rate    (receive_rate),
    .up_time_r       (up_time_r)
  );
  psc_link_partner u_psc_link_partner (
    .clk        (clk),
    .rst        (rst),
    .go         (go),
    .kind       (kind),
    .len        (len),
    .bad        (bad),
    .rx_done    (rx_done),
    .rx_ucast   (rx_ucast),
    .rx_mcast   (rx_mcast),
    .rx_bcast   (rx_bcast),
    .rx_pause   (rx_pause),
    .rx_len     (rx_len),
    .rx_crc_err (rx_crc_err)
  );
  always #5 clk = ~clk;
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      if (err_total == 0 && checks_done > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // frame from the partner; c raises a port clear in the cycle the frame end is taken
  task rx_frame(input [3:0] k, input [13:0] n, input b, input c);
    begin
      go <= 1'b1;
      kind <= k;
      len <= n;
      bad <= b;
      @(posedge clk);
      go <= 1'b0;
      clr_port <= c;
      @(posedge clk);
      clr_port <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  // nc collisions at bit position bp, then the attempt ends
  task tx_send(input [4:0] nc, input [15:0] bp, input [3:0] k, input ok);
    begin
      for (i = 0; i < nc; i = i + 1) begin
        tx_coll <= 1'b1;
        tx_bit_pos <= bp;
        @(posedge clk);
      end
      tx_coll <= 1'b0;
      tx_done <= 1'b1;
      tx_ok <= ok;
      {tx_pause, tx_bcast, tx_mcast, tx_ucast} <= k;
      tx_len <= 14'h0100;
      @(posedge clk);
      tx_done <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  task s_rx_class;
    begin
      for (i = 0; i < 4; i = i + 1)
        rx_frame(4'h1 << i, 14'h0040, 1'b0, 1'b0);
      chk(rx_ucast_cnt, 32'h1);
      chk(rx_mcast_cnt, 32'h1);
      chk(rx_bcast_cnt, 32'h1);
      chk(rx_pause_cnt, 32'h1);
    end
  endtask
  task s_rx_err;
    begin
      rx_frame(4'h1, 14'h07D0, 1'b0, 1'b0);
      chk(rx_len_err_cnt, 32'h1);
      rx_frame(4'h1, 14'h0064, 1'b1, 1'b0);
      rx_frame(4'h1, 14'h003C, 1'b1, 1'b0);
      rx_frame(4'h1, 14'h0040, 1'b1, 1'b0);
      rx_frame(4'h1, 14'h05EE, 1'b0, 1'b0);
      chk(rx_ucast_cnt, 32'h2);
      chk(rx_crc_cnt, 32'h3);
      chk(rx_runt_cnt, 32'h1);
      chk(rx_hist64_cnt, 32'h5);
      chk(rx_err_cnt, 32'h4);
    end
  endtask
  task s_tx;
    begin
      tx_send(5'h00, 16'h0000, 4'h1, 1'b1);
      tx_send(5'h01, 16'h0064, 4'h2, 1'b1);
      tx_send(5'h02, 16'h0200, 4'h4, 1'b1);
      tx_send(5'h01, 16'h0201, 4'h1, 1'b1);
      tx_send(5'h10, 16'h0064, 4'h1, 1'b0);
      tx_send(5'h00, 16'h0000, 4'h8, 1'b1);
      chk(tx_ucast_cnt, 32'h2);
      chk(tx_mcast_cnt, 32'h1);
      chk(tx_bcast_cnt, 32'h1);
      chk(tx_pause_cnt, 32'h1);
      chk(coll_single_cnt, 32'h2);
      chk(coll_multi_cnt, 32'h1);
      chk(coll_excess_cnt, 32'h1);
      chk(coll_late_cnt, 32'h1);
    end
  endtask
  task s_clear;
    begin
      rx_frame(4'h1, 14'h0040, 1'b0, 1'b1);
      chk(rx_ucast_cnt, 32'h0);
      chk(coll_excess_cnt, 32'h0);
      tx_send(5'h00, 16'h0000, 4'h1, 1'b1);
      chk(tx_ucast_cnt, 32'h1);
      chk(transmit_rate, 32'h0);
      chk(receive_rate, 32'h0);
      clr_all <= 1'b1;
      @(posedge clk);
      clr_all <= 1'b0;
      repeat (2) @(posedge clk);
      chk(tx_ucast_cnt, 32'h0);
      link_up <= 1'b0;
      repeat (3) @(posedge clk);
      chk(up_time_r, 32'h0);
    end
  endtask
  // main sequence: reset, scenarios, verdict
  initial begin
    rst = 1'b1;
    {clr_port, clr_all, tx_done, tx_ok, tx_ucast, tx_mcast, tx_bcast, tx_pause, tx_coll} = 9'h000;
    {go, bad, kind, len, tx_len, tx_bit_pos} = 50'h0;
    link_up = 1'b1;
    err_total = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    s_rx_class;
    s_rx_err;
    s_tx;
    s_clear;
    print_verdict;
  end
  // hang guard, far past the hundred or so cycles the scenarios need
  initial begin
    #100000;
    err_total = err_total + 1;
    print_verdict;
  end
endmodule
